// ### design/swc_sleep_wake_controller.sv
`timescale 1ns/1ps
module swc_sleep_wake_controller #(
  parameter int NUM_PREG = swc_pkg::NUM_PREG
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output      logic [31:0]            wb_dat_o,
  output      logic                   wb_ack_o,
  // processor core
  input  wire logic                   sleep_exec,
  output      swc_pkg::swc_core_type  core,
  // interrupt and watchdog events
  input  wire logic [2:0]             int_flag_set,
  input  wire logic [8*NUM_PREG-1:0]  periph_flag_set,
  input  wire logic                   wdt_expired,
  // reset pins
  input  wire logic                   master_clear_pin,
  input  wire logic                   brownout_reset,
  // sleep-time keep-alive controls, reset request and interrupt
  output      swc_pkg::swc_keep_type  keep,
  output      logic                   device_reset_req,
  output      logic                   irq
);

  initial begin
    if (NUM_PREG < 1 || NUM_PREG > 6) begin
      $error("NUM_PREG must be 1 to 6");
    end
  end

  swc_pkg::swc_state_type state;
  swc_pkg::swc_state_type next_state;

  logic [7:0]  global_ctrl;
  logic [7:0]  pie [NUM_PREG];
  logic [7:0]  pir [NUM_PREG];
  logic [7:0]  config_reg;
  logic        power_down_flag_n;
  logic        timeout_flag_n;
  logic [swc_pkg::NUM_EV-1:0] irq_status;
  logic [swc_pkg::NUM_EV-1:0] irq_mask;
  logic [swc_pkg::NUM_EV-1:0] events;
  logic [1:0]  sync_master_clr;
  logic [1:0]  sync_brownout;

  logic        bus_req;
  logic        bus_wr;
  logic        wake_req;
  logic        reset_wake;
  logic        wdt_wake;
  logic        enter_sleep;
  logic        nop_sleep;
  logic        leave_sleep;
  logic        asleep_next;
  logic [31:0] next_rdata;

  function automatic logic preg_hit(input logic [7:0] adr, input logic [7:0] base,
                                    input int idx);
    preg_hit = (adr == 8'(base + 8'(4 * idx)));
  endfunction

  // bus strobes; one cycle to answer every access
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

  // pin synchronisers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_master_clr <= 2'b00;
      sync_brownout   <= 2'b00;
    end else begin
      sync_master_clr <= {sync_master_clr[0], master_clear_pin};
      sync_brownout   <= {sync_brownout[0], brownout_reset};
    end
  end

  // same decision awake and asleep
  assign reset_wake = (sync_master_clr[1] && config_reg[swc_pkg::BIT_MASTER_CLR_EN]) ||
                      (sync_brownout[1] && config_reg[swc_pkg::BIT_BROWNOUT_EN]);

  // global enable deliberately not in the term
  always_comb begin
    wake_req = |(global_ctrl[swc_pkg::INT_EN_LSB +: 3] & global_ctrl[swc_pkg::INT_FLAG_LSB +: 3]);
    for (int i = 0; i < NUM_PREG; i++) begin
      wake_req = wake_req | (|(pie[i] & pir[i]));
    end
  end

  assign wdt_wake = wdt_expired && config_reg[swc_pkg::BIT_WDT_SLEEP];

  always_comb begin
    next_state  = state;
    enter_sleep = 1'b0;
    nop_sleep   = 1'b0;
    leave_sleep = 1'b0;
    unique case (state)
      swc_pkg::ST_RUN: begin
        if (sleep_exec && !reset_wake) begin
          if (wake_req) begin
            nop_sleep = 1'b1;
          end else begin
            enter_sleep = 1'b1;
            next_state  = swc_pkg::ST_SLEEP;
          end
        end
      end
      swc_pkg::ST_SLEEP: begin
        // a flag raised during entry is seen here, one cycle later
        if (reset_wake) begin
          next_state = swc_pkg::ST_RUN;
        end else if (wake_req || wdt_wake) begin
          leave_sleep = 1'b1;
          next_state  = swc_pkg::ST_WAKE;
        end
      end
      swc_pkg::ST_WAKE: begin
        next_state = swc_pkg::ST_RUN;
      end
      default: begin
        next_state = swc_pkg::ST_RUN;
      end
    endcase
  end

  assign asleep_next = (next_state == swc_pkg::ST_SLEEP);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= swc_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // processor handshake
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      core <= '{clk_en: 1'b1, prefetch: 1'b0, resume: 1'b0, isr_call: 1'b0};
    end else begin
      core.clk_en   <= !asleep_next;
      core.prefetch <= sleep_exec && state == swc_pkg::ST_RUN;
      core.resume   <= leave_sleep;
      // core runs the prefetched instruction first, then takes the vector
      core.isr_call <= leave_sleep && global_ctrl[swc_pkg::BIT_GLOBAL_EN];
    end
  end

  // what keeps running while asleep
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      keep <= '{wdt_run: 1'b1, wdt_clear: 1'b0, lfosc_run: 1'b1,
                timer1_run: 1'b1, adc_run: 1'b1, io_hold: 1'b0};
    end else begin
      keep.wdt_run    <= !asleep_next || config_reg[swc_pkg::BIT_WDT_SLEEP];
      keep.wdt_clear  <= enter_sleep || leave_sleep;
      keep.lfosc_run  <= 1'b1;
      keep.timer1_run <= !asleep_next ||
                         (config_reg[swc_pkg::T1_SEL_LSB +: 2] != swc_pkg::T1_SYSCLK);
      keep.adc_run    <= !asleep_next || config_reg[swc_pkg::BIT_ADC_RC];
      keep.io_hold    <= asleep_next;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= reset_wake;
    end
  end

  // status flags; a software one re-arms them, hardware events win
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      power_down_flag_n <= swc_pkg::STATUS_RST[swc_pkg::BIT_POWER_DOWN_N];
      timeout_flag_n    <= swc_pkg::STATUS_RST[swc_pkg::BIT_TIMEOUT_N];
    end else begin
      if (enter_sleep) begin
        power_down_flag_n <= 1'b0;
        timeout_flag_n    <= 1'b1;
      end else if (state == swc_pkg::ST_SLEEP && !wake_req && wdt_wake && !reset_wake) begin
        timeout_flag_n <= 1'b0;
      end else if (bus_wr && wb_adr_i == swc_pkg::OFS_STATUS) begin
        power_down_flag_n <= power_down_flag_n | wb_dat_i[swc_pkg::BIT_POWER_DOWN_N];
        timeout_flag_n    <= timeout_flag_n | wb_dat_i[swc_pkg::BIT_TIMEOUT_N];
      end
    end
  end

  // interrupt flag registers, set wins over a write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      global_ctrl <= 8'h00;
    end else begin
      if (bus_wr && wb_adr_i == swc_pkg::OFS_GLOBAL_CTRL) begin
        global_ctrl <= wb_dat_i[7:0] | {5'h00, int_flag_set};
      end else begin
        global_ctrl <= global_ctrl | {5'h00, int_flag_set};
      end
    end
  end

  for (genvar g = 0; g < NUM_PREG; g++) begin : g_preg
    localparam logic [7:0] IMPL = swc_pkg::PREG_IMPL[8*g +: 8];
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        pie[g] <= 8'h00;
        pir[g] <= 8'h00;
      end else begin
        if (bus_wr && preg_hit(wb_adr_i, swc_pkg::OFS_PIE_BASE, g)) begin
          pie[g] <= wb_dat_i[7:0] & IMPL;
        end
        if (bus_wr && preg_hit(wb_adr_i, swc_pkg::OFS_PIR_BASE, g)) begin
          pir[g] <= (wb_dat_i[7:0] | periph_flag_set[8*g +: 8]) & IMPL;
        end else begin
          pir[g] <= (pir[g] | periph_flag_set[8*g +: 8]) & IMPL;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_reg <= swc_pkg::CONFIG_RST;
      irq_mask   <= '0;
    end else begin
      if (bus_wr && wb_adr_i == swc_pkg::OFS_CONFIG) begin
        config_reg <= wb_dat_i[7:0] & 8'h77;
      end
      if (bus_wr && wb_adr_i == swc_pkg::OFS_IRQ_MASK) begin
        irq_mask <= wb_dat_i[swc_pkg::NUM_EV-1:0];
      end
    end
  end

  // sticky events, write one to clear, a new event wins
  always_comb begin
    events = '0;
    events[swc_pkg::EV_SLEPT]     = enter_sleep;
    events[swc_pkg::EV_WOKE]      = leave_sleep;
    events[swc_pkg::EV_SLEEP_NOP] = nop_sleep;
    events[swc_pkg::EV_RESET]     = reset_wake && !device_reset_req;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      if (bus_wr && wb_adr_i == swc_pkg::OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wb_dat_i[swc_pkg::NUM_EV-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // read mux; unmapped words read zero and are still acknowledged
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == swc_pkg::OFS_GLOBAL_CTRL) begin
      next_rdata[7:0] = global_ctrl;
    end
    if (wb_adr_i == swc_pkg::OFS_CONFIG) begin
      next_rdata[7:0] = config_reg;
    end
    if (wb_adr_i == swc_pkg::OFS_STATUS) begin
      next_rdata[swc_pkg::BIT_TIMEOUT_N]    = timeout_flag_n;
      next_rdata[swc_pkg::BIT_POWER_DOWN_N] = power_down_flag_n;
      next_rdata[swc_pkg::BIT_ASLEEP] = (state == swc_pkg::ST_SLEEP);
    end
    if (wb_adr_i == swc_pkg::OFS_IRQ_STATUS) begin
      next_rdata[swc_pkg::NUM_EV-1:0] = irq_status;
    end
    if (wb_adr_i == swc_pkg::OFS_IRQ_MASK) begin
      next_rdata[swc_pkg::NUM_EV-1:0] = irq_mask;
    end
    for (int i = 0; i < NUM_PREG; i++) begin
      if (preg_hit(wb_adr_i, swc_pkg::OFS_PIE_BASE, i)) begin
        next_rdata[7:0] = pie[i];
      end
      if (preg_hit(wb_adr_i, swc_pkg::OFS_PIR_BASE, i)) begin
        next_rdata[7:0] = pir[i];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_enter;
    state == swc_pkg::ST_RUN ##1 state == swc_pkg::ST_SLEEP;
  endsequence

  sequence s_leave;
    state == swc_pkg::ST_SLEEP ##1 state == swc_pkg::ST_WAKE;
  endsequence

  sequence s_held;
    state == swc_pkg::ST_SLEEP ##1 state == swc_pkg::ST_SLEEP;
  endsequence

  sequence s_nop_instr;
    state == swc_pkg::ST_RUN && sleep_exec && wake_req && !reset_wake;
  endsequence

  a_sleep_only_instr: assert property (s_enter |-> $past(sleep_exec, 1))
    else $error("sleep entered without sleep instruction");
  a_entry_flags_set: assert property (s_enter |-> !power_down_flag_n && timeout_flag_n)
    else $error("entry status flags wrong");
  a_entry_wdt_clear: assert property (s_enter |-> keep.wdt_clear)
    else $error("watchdog not cleared on entry");
  a_clock_gated: assert property (state == swc_pkg::ST_SLEEP |-> !core.clk_en)
    else $error("clock not gated in sleep");
  a_pins_held: assert property (state == swc_pkg::ST_SLEEP |-> keep.io_hold)
    else $error("pins not held in sleep");
  a_lfosc_kept: assert property (state == swc_pkg::ST_SLEEP |-> keep.lfosc_run)
    else $error("low-frequency oscillator stopped in sleep");
  a_timer_one_run: assert property (s_held |-> keep.timer1_run == |$past(config_reg[5:4]))
    else $error("timer one run state wrong in sleep");
  a_adc_rc_run: assert property (s_held |-> keep.adc_run == $past(config_reg[6]))
    else $error("converter run state wrong in sleep");
  a_wdt_sleep_run: assert property (s_held |-> keep.wdt_run == $past(config_reg[0]))
    else $error("watchdog run state wrong in sleep");
  a_reset_wake: assert property (reset_wake |=> device_reset_req)
    else $error("reset source did not request reset");
  a_reset_to_run: assert property (reset_wake |=> state == swc_pkg::ST_RUN)
    else $error("reset source did not end sleep");
  a_wake_resume: assert property (s_leave |-> core.resume && core.clk_en)
    else $error("wake without resume");
  a_wake_wdt_clear: assert property (s_leave |-> keep.wdt_clear)
    else $error("wake without watchdog clear");
  a_isr_follows_enable: assert property (core.resume |->
                                         core.isr_call == $past(global_ctrl[7]))
    else $error("service call does not follow global enable");
  a_nop_sleep_keeps: assert property (s_nop_instr |=>
                                      state == swc_pkg::ST_RUN && $stable(power_down_flag_n)
                                      && !keep.wdt_clear)
    else $error("pending flag did not make sleep a no-operation");
  a_late_flag_wakes: assert property (s_enter ##0 (wake_req && !reset_wake) |=>
                                      state == swc_pkg::ST_WAKE)
    else $error("flag during entry did not wake at once");
  a_own_enable_wakes: assert property (state == swc_pkg::ST_SLEEP && wake_req
                                       && !reset_wake |=> state == swc_pkg::ST_WAKE)
    else $error("enabled flag did not wake");
  a_prefetch_next: assert property (state == swc_pkg::ST_RUN && sleep_exec |=>
                                    core.prefetch)
    else $error("no prefetch during sleep instruction");

endmodule

// ### inc/swc_pkg.sv
package swc_pkg;

  localparam int NUM_PREG = 6;

  // register byte addresses, one 32-bit word each
  localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] OFS_PIE_BASE   = 8'h04;
  localparam logic [7:0] OFS_PIR_BASE   = 8'h1C;
  localparam logic [7:0] OFS_STATUS     = 8'h34;
  localparam logic [7:0] OFS_CONFIG     = 8'h38;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h3C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h40;

  // global interrupt control fields
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_PERIPH_GATE = 6;
  localparam int INT_EN_LSB   = 3;
  localparam int INT_FLAG_LSB = 0;

  // status fields
  localparam int BIT_TIMEOUT_N    = 4;
  localparam int BIT_POWER_DOWN_N = 3;
  localparam int BIT_ASLEEP = 0;
  localparam logic [7:0] STATUS_RST = 8'h18;

  // configuration fields
  localparam int BIT_WDT_SLEEP = 0;
  localparam int BIT_MASTER_CLR_EN = 1;
  localparam int BIT_BROWNOUT_EN   = 2;
  localparam int T1_SEL_LSB    = 4;
  localparam int BIT_ADC_RC    = 6;
  localparam logic [7:0] CONFIG_RST = 8'h06;

  // interrupt status events
  localparam int EV_SLEPT     = 0;
  localparam int EV_WOKE      = 1;
  localparam int EV_SLEEP_NOP = 2;
  localparam int EV_RESET     = 3;
  localparam int NUM_EV       = 4;

  // implemented bits of the six peripheral enable/request registers
  localparam logic [47:0] PREG_IMPL = 48'h0F_FF_7F_3F_FF_FF;

  typedef enum logic [1:0] {
    T1_SYSCLK = 2'b00,
    T1_LFOSC  = 2'b01,
    T1_EXT    = 2'b10,
    T1_SECOND = 2'b11
  } swc_t1_clk_type;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE  = 3'b100
  } swc_state_type;

  typedef struct packed {
    logic clk_en;
    logic prefetch;
    logic resume;
    logic isr_call;
  } swc_core_type;

  typedef struct packed {
    logic wdt_run;
    logic wdt_clear;
    logic lfosc_run;
    logic timer1_run;
    logic adc_run;
    logic io_hold;
  } swc_keep_type;

endpackage

// ### verif/sleep_wake_controller_tb.sv
`timescale 1ns/1ps
module sleep_wake_controller_tb;
  logic                  clk_sys;
  logic                  reset;
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  logic                  wb_we_i;
  logic [7:0]            wb_adr_i;
  logic [31:0]           wb_dat_i;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  sleep_exec;
  logic                  go;
  swc_pkg::swc_core_type core;
  swc_pkg::swc_keep_type keep;
  logic [2:0]            int_flag_set;
  logic [47:0]           periph_flag_set;
  logic                  wdt_expired;
  logic                  master_clear_pin;
  logic                  brownout_reset;
  logic                  device_reset_req;
  logic                  irq;
  int                    miscompares;
  int                    checks_done;
  logic [31:0]           rows [17];
  logic [23:0]           cases [5];

  swc_sleep_wake_controller i_dut (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_exec(sleep_exec), .core(core),
    .int_flag_set(int_flag_set), .periph_flag_set(periph_flag_set),
    .wdt_expired(wdt_expired), .master_clear_pin(master_clear_pin),
    .brownout_reset(brownout_reset), .keep(keep), .device_reset_req(device_reset_req),
    .irq(irq)
  );

  swc_core_model i_core (
    .clk_sys(clk_sys), .reset(reset), .go(go), .core(core), .sleep_exec(sleep_exec)
  );

  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    miscompares++;
    complete_run();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      miscompares++;
    end
  endtask

  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h00_0000, wd};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) timeout();
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] d;
    wb_io(1'b1, adr, wd, d);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_io(1'b0, adr, 8'h00, d);
    check(d, exp);
  endtask

  // bounded wait on resume or on the reset request
  task automatic wait_sig(input logic want_rst, input logic lvl);
    int n;
    #1;
    for (n = 0; n < 20 && (want_rst ? device_reset_req : core.resume) !== lvl; n++) begin
      @(posedge clk_sys);
      #1;
    end
    if (n == 20) timeout();
  endtask

  // flag may land in the same cycle as the sleep instruction
  task automatic sleep_now(input logic flag_in_entry);
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    int_flag_set[0] <= flag_in_entry;
    @(posedge clk_sys);
    int_flag_set[0] <= 1'b0;
    #1;
  endtask

  task automatic fire(input int src);
    @(posedge clk_sys);
    int_flag_set[0] <= (src == 0);
    periph_flag_set[0] <= (src == 1);
    wdt_expired <= (src == 2);
    @(posedge clk_sys);
    int_flag_set[0] <= 1'b0;
    periph_flag_set[0] <= 1'b0;
    wdt_expired <= 1'b0;
  endtask

  task automatic check_rst();
    #1;
    check(core, 4'b1000);
    check(keep, 6'b101110);
    check(device_reset_req, 1'b0);
    check(irq, 1'b0);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    logic [7:0] cfg;
    logic [7:0] ic;
    int         src;
    miscompares = 0;
    checks_done = 0;
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go, wdt_expired} = '0;
    {master_clear_pin, brownout_reset} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    int_flag_set = 3'h0;
    periph_flag_set = '0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    check_rst();
    for (int g = 0; g < 6; g++) begin
      rows[g] = {swc_pkg::OFS_PIE_BASE + 8'(4 * g), 8'hFF, swc_pkg::PREG_IMPL[8*g +: 8], 8'h00};
      rows[g+6] = {swc_pkg::OFS_PIR_BASE + 8'(4 * g), 8'hFF, swc_pkg::PREG_IMPL[8*g +: 8], 8'h00};
    end
    rows[12] = {swc_pkg::OFS_GLOBAL_CTRL, 8'hF8, 8'hF8, 8'h00};
    rows[13] = {swc_pkg::OFS_CONFIG, 8'h37, 8'h37, 8'h06};
    rows[14] = {swc_pkg::OFS_STATUS, 8'h00, 8'h18, 8'h00};
    rows[15] = {8'h80, 8'hA5, 8'h00, 8'h00};
    rows[16] = {swc_pkg::OFS_IRQ_MASK, 8'h0F, 8'h0F, 8'h00};
    foreach (rows[i]) begin
      rdc(rows[i][31:24], (i == 13) ? 32'h06 : (i == 14) ? 32'h18 : 32'h00);
      wr(rows[i][31:24], rows[i][23:16]);
      rdc(rows[i][31:24], {24'h00_0000, rows[i][15:8]});
      wr(rows[i][31:24], rows[i][7:0]);
    end
    // config, global control, wake source (3: flag lands during entry)
    cases = '{24'h56_0800, 24'h06_8800, 24'h26_0001, 24'h37_0002, 24'h16_8803};
    foreach (cases[c]) begin
      cfg = cases[c][23:16];
      ic = cases[c][15:8];
      src = int'(cases[c][7:0]);
      wr(swc_pkg::OFS_CONFIG, cfg);
      wr(swc_pkg::OFS_GLOBAL_CTRL, ic | ((src == 3) ? 8'h08 : 8'h00));
      wr(swc_pkg::OFS_PIE_BASE, (src == 1) ? 8'h01 : 8'h00);
      wr(swc_pkg::OFS_STATUS, 8'h18);
      sleep_now(src == 3);
      check(core.clk_en, 1'b0);
      check(core.prefetch, 1'b1);
      check(keep.wdt_clear, 1'b1);
      check(keep.wdt_run, cfg[0]);
      check(keep.io_hold, 1'b1);
      check(keep.lfosc_run, 1'b1);
      check(keep.timer1_run, cfg[5:4] != 2'b00);
      check(keep.adc_run, cfg[6]);
      if (src != 3) begin
        rdc(swc_pkg::OFS_STATUS, 32'h11);
        fire(src);
      end
      wait_sig(1'b0, 1'b1);
      check(core.isr_call, ic[7]);
      check(keep.wdt_clear, 1'b1);
      @(posedge clk_sys);
      #1;
      check({core.clk_en, keep.io_hold}, 2'b10);
      rdc(swc_pkg::OFS_STATUS, (src == 2) ? 32'h00 : 32'h10);
      wr(swc_pkg::OFS_GLOBAL_CTRL, 8'h00);
      wr(swc_pkg::OFS_PIR_BASE, 8'h00);
      wr(swc_pkg::OFS_PIE_BASE, 8'h00);
    end
    // flag already pending: sleep only raises the prefetch and reports it
    wr(swc_pkg::OFS_GLOBAL_CTRL, 8'h08);
    fire(0);
    wr(swc_pkg::OFS_STATUS, 8'h18);
    rdc(swc_pkg::OFS_IRQ_STATUS, 32'h03);
    wr(swc_pkg::OFS_IRQ_STATUS, 8'h0F);
    sleep_now(1'b0);
    check({core.clk_en, core.prefetch, keep.wdt_clear}, 3'b110);
    rdc(swc_pkg::OFS_STATUS, 32'h18);
    rdc(swc_pkg::OFS_IRQ_STATUS, 32'h04);
    check(irq, 1'b0);
    wr(swc_pkg::OFS_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1;
    check(irq, 1'b1);
    wr(swc_pkg::OFS_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1;
    check(irq, 1'b0);
    wr(swc_pkg::OFS_GLOBAL_CTRL, 8'h00);
    wr(swc_pkg::OFS_IRQ_MASK, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(swc_pkg::OFS_CONFIG, 8'h06);
      sleep_now(1'b0);
      @(posedge clk_sys);
      master_clear_pin <= (p == 0);
      brownout_reset <= (p == 1);
      wait_sig(1'b1, 1'b1);
      @(posedge clk_sys);
      #1;
      check({device_reset_req, core.clk_en}, 2'b11);
      @(posedge clk_sys);
      master_clear_pin <= 1'b0;
      brownout_reset <= 1'b0;
      wait_sig(1'b1, 1'b0);
    end
    rdc(swc_pkg::OFS_IRQ_STATUS, 32'h09);
    // pin ignored once its enable is off
    wr(swc_pkg::OFS_CONFIG, 8'h04);
    @(posedge clk_sys);
    master_clear_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    check(device_reset_req, 1'b0);
    master_clear_pin <= 1'b0;
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    check_rst();
    rdc(swc_pkg::OFS_CONFIG, 32'h06);
    complete_run();
  end
endmodule

// ### verif/swc_core_model.sv
`timescale 1ns/1ps
// processor side of the controller: runs the sleep instruction when the bench asks
module swc_core_model (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // bench request
  input  wire logic                  go,
  // controller side
  input  wire swc_pkg::swc_core_type core,
  output      logic                  sleep_exec
);
  // a gated core fetches nothing, so no sleep instruction while stopped
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sleep_exec <= 1'b0;
    end else begin
      sleep_exec <= go && core.clk_en;
    end
  end
endmodule
